// File: verilog/blk_pkg.sv
// shared constants for the serial flash block-lock and soft-reset logic
// assumes a 100 MHz system clock and an spi host on the far side
package blk_pkg;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_LOCK_ONE = 8'h36;
  localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
  localparam logic [7:0] OP_READ_LOCK = 8'h3D;
  localparam logic [7:0] OP_LOCK_ALL = 8'h7E;
  localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam logic [5:0] OPCODE_BITS = 6'd8;
  localparam logic [5:0] FRAME_BITS_3B = 6'd32;
  localparam logic [5:0] FRAME_BITS_4B = 6'd40;
  localparam logic [5:0] COUNT_MAX = 6'h3F;
  localparam int BLOCK_SHIFT = 16;
  localparam int LOCK_READ_WIDTH = 8;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int RESET_TIME_NS = 30000;
  localparam int RESET_CYCLES = RESET_TIME_NS / CLOCK_PERIOD_NS;
  localparam int BUSY_W = 12;
  localparam int SUPPLY_TO_SELECT_DELAY_US = 20;
  localparam int POWER_UP_WRITE_DELAY_MS = 5;
  // lock bits come up set, the whole array protected
  localparam logic LOCK_RESET_VALUE = 1'b1;
  // ----------------------------------------
  // command sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_READ} blk_state_t;
endpackage : blk_pkg

// File: verilog/blk_lock_array.sv
// volatile lock bit array, one bit per block
// assumes strobes come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module blk_lock_array #(
  parameter int NUM_BLOCKS = 512,
  parameter int IDX_W = 9
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic set_one,
  input wire logic clr_one,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic set_all,
  input wire logic clr_all,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic rd_val,
  input wire logic [IDX_W-1:0] chk_idx,
  output logic chk_val
);
  import blk_pkg::*;

  if (NUM_BLOCKS < 2 || NUM_BLOCKS > (1 << IDX_W)) begin : g_chk
    $error("NUM_BLOCKS does not fit the index width");
  end

  typedef struct packed {
    logic [NUM_BLOCKS-1:0] locks;
  } blk_arr_t;

  blk_arr_t s_ff;
  blk_arr_t nxt_s;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // set-all wins over clear-all so a soft reset never leaves blocks open
  always_comb begin
    nxt_s = s_ff;
    if (set_all) begin
      nxt_s.locks = {NUM_BLOCKS{LOCK_RESET_VALUE}}; // see RL8 see RL3
    end else if (clr_all) begin
      nxt_s.locks = '0; // see RL9
    end else if (set_one) begin
      nxt_s.locks[wr_idx] = 1'b1; // see RL4
    end else if (clr_one) begin
      nxt_s.locks[wr_idx] = 1'b0; // see RL5
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_ff <= '{locks: {NUM_BLOCKS{LOCK_RESET_VALUE}}}; // see RL3
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_val = s_ff.locks[rd_idx];
  assign chk_val = s_ff.locks[chk_idx];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  all_set_a: assert property (@(posedge clock) disable iff (reset) // see RL8
    set_all |=> (&s_ff.locks)) else $error("global lock left a bit clear");
  all_clear_a: assert property (@(posedge clock) disable iff (reset) // see RL9
    (clr_all && !set_all) |=> (s_ff.locks == '0)) else $error("global unlock left a bit set");
  init_ones_a: assert property (@(posedge clock) // see RL3
    $past(reset) |-> (&s_ff.locks)) else $error("lock bits not set after reset");
  one_clear_a: assert property (@(posedge clock) disable iff (reset) // see RL5
    (clr_one && !set_one && !set_all && !clr_all) |=> !s_ff.locks[$past(wr_idx)])
    else $error("unlock did not clear its bit");
endmodule : blk_lock_array
`default_nettype wire

// File: verilog/blk_lock_ctrl.sv
// serial command front end for block locks and the two-step soft reset
// assumes spi pins are asynchronous to CLOCK and sclk is far slower than CLOCK
// Behaviour
// RL1: lock bits guard writes only when mode set
// RL2: otherwise protect by complement, top/bottom, level
// RL3: lock bits volatile, all one after reset
// RL4: 36h plus address locks that block
// RL5: 39h plus address unlocks that block
// RL6: 3Dh plus address shifts lock value out
// RL7: returned lsb one means locked
// RL8: 7Eh alone sets every lock bit
// RL9: 98h alone clears every lock bit
// RL10: opcode bits captured on sclk rising edges
// RL11: four-byte mode expects 32-bit address
// RL12: soft reset restores all volatile defaults
// RL13: reset needs 66h directly before 99h
// RL14: any other command disarms pending reset
// RL15: reset lasts 30 us, commands rejected
// RL16: host checks busy and suspend first
// RL17: host waits 20 us before select
// RL18: host waits 5 ms before writes
// RL19: locked block ignores erase or program
`timescale 1ns/1ps
`default_nettype none
module blk_lock_ctrl #(
  parameter int NUM_BLOCKS = 512,
  parameter int IDX_W = 9
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_DI,
  output logic SPI_DO,
  output logic SPI_DO_OE,
  input wire logic FOUR_BYTE_MODE,
  input wire logic LOCK_MODE_SELECT,
  input wire logic PROTECT_COMPLEMENT,
  input wire logic TOP_BOTTOM_SELECT,
  input wire logic [3:0] BLOCK_PROTECT_LEVEL,
  input wire logic [31:0] WRITE_CHECK_ADDR,
  output logic WRITE_PERMIT,
  output logic VOLATILE_CLEAR,
  output logic RESET_BUSY
);
  import blk_pkg::*;

  if (NUM_BLOCKS < 2 || (1 << IDX_W) != NUM_BLOCKS || IDX_W + BLOCK_SHIFT > 32) begin : g_chk
    $error("NUM_BLOCKS must equal 2**IDX_W and fit the address");
  end

  typedef struct packed {
    logic cs_s1, cs_s2, cs_prev;
    logic ck_s1, ck_s2, ck_prev;
    logic di_s1, di_s2;
    blk_state_t state;
    logic [5:0] cnt;
    logic [39:0] sh;
    logic [7:0] out_sh;
    logic do_ff, oe_ff, armed, clr, permit;
    logic [BUSY_W-1:0] busy;
  } blk_ctl_t;

  blk_ctl_t s_ff;
  blk_ctl_t nxt_s;
  logic set_one, clr_one, set_all, clr_all;
  logic rd_val, chk_val;
  logic [IDX_W-1:0] wr_idx, rd_idx, chk_idx;
  logic [39:0] shifted;
  logic [5:0] frame_len;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // the opcode sits above the address, whose width follows the address mode
  function automatic logic [7:0] frame_op(input logic [39:0] sh, input logic four);
    return four ? sh[39:32] : sh[31:24]; // see RL11
  endfunction : frame_op

  function automatic logic [IDX_W-1:0] frame_blk(input logic [39:0] sh, input logic four);
    logic [31:0] addr;
    addr = four ? sh[31:0] : {8'h00, sh[23:0]};
    return addr[BLOCK_SHIFT +: IDX_W];
  endfunction : frame_blk

  // before the complement, level 0 protects nothing; level n protects 2**(n-1) blocks from one end
  function automatic logic level_protects(input logic [IDX_W-1:0] blk, input logic [3:0] lvl,
                                          input logic from_bottom, input logic invert);
    int unsigned span;
    logic hit;
    span = (lvl == 4'h0) ? 0 : (32'd1 << (lvl - 4'h1));
    hit = from_bottom ? (32'(blk) < span) : (32'(blk) + span >= NUM_BLOCKS);
    return hit ^ invert;
  endfunction : level_protects

  // ----------------------------------------
  // pin edges, all from the second stage onward
  // ----------------------------------------
  assign sclk_rise = s_ff.ck_s2 & ~s_ff.ck_prev; // see RL10
  assign sclk_fall = ~s_ff.ck_s2 & s_ff.ck_prev;
  assign cs_fall = ~s_ff.cs_s2 & s_ff.cs_prev;
  assign cs_rise = s_ff.cs_s2 & ~s_ff.cs_prev;
  assign shifted = {s_ff.sh[38:0], s_ff.di_s2};
  assign frame_len = FOUR_BYTE_MODE ? FRAME_BITS_4B : FRAME_BITS_3B; // see RL11
  assign wr_idx = frame_blk(s_ff.sh, FOUR_BYTE_MODE);
  assign rd_idx = frame_blk(shifted, FOUR_BYTE_MODE);
  assign chk_idx = WRITE_CHECK_ADDR[BLOCK_SHIFT +: IDX_W];

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  // commands other than the lock read act on select rising so a frame cut short never takes effect
  always_comb begin
    nxt_s = s_ff;
    set_one = 1'b0;
    clr_one = 1'b0;
    set_all = 1'b0;
    clr_all = 1'b0;
    nxt_s.cs_s1 = SPI_CS_N;
    nxt_s.cs_s2 = s_ff.cs_s1;
    nxt_s.cs_prev = s_ff.cs_s2;
    nxt_s.ck_s1 = SPI_SCLK;
    nxt_s.ck_s2 = s_ff.ck_s1;
    nxt_s.ck_prev = s_ff.ck_s2;
    nxt_s.di_s1 = SPI_DI;
    nxt_s.di_s2 = s_ff.di_s1;
    nxt_s.clr = 1'b0;
    if (s_ff.busy != '0) begin
      nxt_s.busy = s_ff.busy - 1'b1; // see RL15
    end
    case (s_ff.state)
      ST_IDLE: begin
        nxt_s.oe_ff = 1'b0;
        if (cs_fall) begin
          nxt_s.state = ST_CMD;
          nxt_s.cnt = '0;
        end
      end
      ST_CMD: begin
        if (cs_rise) begin
          nxt_s.state = ST_IDLE;
          // while resetting every frame is dropped, armed state untouched
          if (s_ff.busy == '0 && s_ff.cnt >= OPCODE_BITS) begin // see RL15
            nxt_s.armed = 1'b0; // see RL14
            if (s_ff.cnt == OPCODE_BITS) begin
              case (s_ff.sh[7:0])
                OP_LOCK_ALL: set_all = 1'b1; // see RL8
                OP_UNLOCK_ALL: clr_all = 1'b1; // see RL9
                OP_RESET_ENABLE: nxt_s.armed = 1'b1; // see RL13
                OP_RESET_DEVICE: begin
                  if (s_ff.armed) begin // see RL13
                    set_all = 1'b1; // see RL3
                    nxt_s.clr = 1'b1; // see RL12
                    nxt_s.busy = BUSY_W'(RESET_CYCLES); // see RL15
                  end
                end
                default: ;
              endcase
            end else if (s_ff.cnt == frame_len) begin
              set_one = (frame_op(s_ff.sh, FOUR_BYTE_MODE) == OP_LOCK_ONE); // see RL4
              clr_one = (frame_op(s_ff.sh, FOUR_BYTE_MODE) == OP_UNLOCK_ONE); // see RL5
            end
          end
        end else if (sclk_rise) begin
          nxt_s.sh = shifted; // see RL10
          if (s_ff.cnt != COUNT_MAX) begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
          end
          if (s_ff.cnt + 1'b1 == frame_len && s_ff.busy == '0 &&
              frame_op(shifted, FOUR_BYTE_MODE) == OP_READ_LOCK) begin
            nxt_s.state = ST_READ; // see RL6
            nxt_s.out_sh = {{(LOCK_READ_WIDTH-1){1'b0}}, rd_val}; // see RL7
          end
        end
      end
      ST_READ: begin
        if (cs_rise) begin
          nxt_s.state = ST_IDLE;
          nxt_s.oe_ff = 1'b0;
          nxt_s.armed = 1'b0; // see RL14
        end else if (sclk_fall) begin
          // msb first, the value repeats while the host keeps clocking
          nxt_s.do_ff = s_ff.out_sh[7]; // see RL6
          nxt_s.out_sh = {s_ff.out_sh[6:0], s_ff.out_sh[7]};
          nxt_s.oe_ff = 1'b1;
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase
    // write gate for the array engine; registered, so it closes one cycle after RESET_BUSY rises
    if (LOCK_MODE_SELECT) begin
      nxt_s.permit = ~chk_val & (s_ff.busy == '0); // see RL1 see RL19
    end else begin
      nxt_s.permit = ~level_protects(chk_idx, BLOCK_PROTECT_LEVEL, TOP_BOTTOM_SELECT,
                                  PROTECT_COMPLEMENT) & (s_ff.busy == '0); // see RL2
    end
  end

  // select stages load high so no false select edge is seen out of reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      s_ff <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, state: ST_IDLE, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  blk_lock_array #(.NUM_BLOCKS(NUM_BLOCKS), .IDX_W(IDX_W)) u_locks (
    .clock(CLOCK),
    .reset(RESET),
    .set_one(set_one),
    .clr_one(clr_one),
    .wr_idx(wr_idx),
    .set_all(set_all),
    .clr_all(clr_all),
    .rd_idx(rd_idx),
    .rd_val(rd_val),
    .chk_idx(chk_idx),
    .chk_val(chk_val)
  );

  assign SPI_DO = s_ff.do_ff;
  assign SPI_DO_OE = s_ff.oe_ff;
  assign WRITE_PERMIT = s_ff.permit;
  assign VOLATILE_CLEAR = s_ff.clr;
  assign RESET_BUSY = (s_ff.busy != '0);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // the interval is loaded in the same edge that raises the clear pulse
  busy_start_a: assert property (VOLATILE_CLEAR |-> s_ff.busy == BUSY_W'(RESET_CYCLES)) // see RL15
    else $error("reset interval not loaded");
  busy_reject_a: assert property ( // see RL15
    RESET_BUSY |-> !(set_one || clr_one || clr_all || nxt_s.clr))
    else $error("command accepted while resetting");
  reset_needs_arm_a: assert property ( // see RL13
    nxt_s.clr |-> s_ff.armed && s_ff.sh[7:0] == OP_RESET_DEVICE)
    else $error("reset without enable");
  clear_locks_a: assert property (VOLATILE_CLEAR |-> $past(set_all)) // see RL12
    else $error("soft reset did not relock");
  disarm_other_a: assert property ((cs_rise && s_ff.state == ST_CMD && s_ff.busy == '0 && // see RL14
    s_ff.cnt > OPCODE_BITS) |=> !s_ff.armed) else $error("reset stayed armed");
  out_only_read_a: assert property (SPI_DO_OE |-> s_ff.state == ST_READ) // see RL6
    else $error("data out driven outside lock read");
  read_value_a: assert property ($rose(s_ff.state == ST_READ) |-> // see RL7
    s_ff.out_sh[7:1] == 7'h00 && s_ff.out_sh[0] == $past(rd_val))
    else $error("lock value wrong");
  lock_gate_a: assert property ((LOCK_MODE_SELECT && chk_val) |=> !WRITE_PERMIT) // see RL19
    else $error("locked block write permitted");
  mode_off_a: assert property ((!LOCK_MODE_SELECT && !RESET_BUSY && // see RL2
    BLOCK_PROTECT_LEVEL == 4'h0 && !PROTECT_COMPLEMENT) |=> WRITE_PERMIT)
    else $error("lock bits used with mode off");

  soft_reset_c: cover property (VOLATILE_CLEAR);
  lock_read_c: cover property (SPI_DO_OE ##1 !SPI_DO_OE);
  lock_one_c: cover property (set_one);
  unlock_all_c: cover property (clr_all);
endmodule : blk_lock_ctrl
`default_nettype wire

// File: verification/blk_spi_host.sv
// behavioural serial host that frames commands towards the lock front end
// assumes a free-running CLOCK; sclk is made here at one eighth of its rate
`timescale 1ns/1ps
`default_nettype none
module blk_spi_host (
  input wire logic CLOCK,
  input wire logic SPI_DO,
  output logic SPI_CS_N,
  output logic SPI_SCLK,
  output logic SPI_DI
);
  // ----------------------------------------
  // idle levels: deselected, clock parked low
  // ----------------------------------------
  initial begin
    SPI_CS_N = 1'b1;
    SPI_SCLK = 1'b0;
    SPI_DI = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : tick

  // ----------------------------------------
  // one frame: bits left-aligned, then nrd bits read back
  // ----------------------------------------
  task automatic frame(input logic [39:0] bits, input int n, input int nrd,
                       output logic [7:0] rd);
    rd = 8'h00;
    SPI_CS_N <= 1'b0;
    tick(4);
    // opcode then address, msb first, data set up half a period before the rise
    for (int i = 0; i < n; i++) begin
      SPI_DI <= bits[39-i];
      tick(4);
      SPI_SCLK <= 1'b1;
      tick(4);
      SPI_SCLK <= 1'b0;
    end
    // sample late in each period: the sclk fall crosses two sync stages before the output changes
    for (int j = 0; j < nrd; j++) begin
      tick(4);
      SPI_SCLK <= 1'b1;
      tick(4);
      rd = {rd[6:0], SPI_DO};
      SPI_SCLK <= 1'b0;
    end
    SPI_DI <= ~SPI_DI; // released line shows a changed level, not the last bit
    tick(4);
    SPI_CS_N <= 1'b1;
    tick(8);
  endtask : frame
endmodule : blk_spi_host
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the block lock and soft reset front end
// assumes blk_spi_host drives the serial pins; every other input is driven here
`timescale 1ns/1ps
`default_nettype none
module tb;
  import blk_pkg::*;
  logic clock, reset, cs_n, sclk, di, do_w, do_oe, four_b, lms, comp_w, top_w;
  logic permit, vclear, busy, do_line;
  logic [3:0] lvl;
  logic [31:0] wr_addr;
  logic [7:0] rd;
  int errors = 0;
  int samples_checked = 0;
  int busy_cnt = 0;
  int clr_cnt = 0;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  blk_lock_ctrl u_blk_lock_ctrl (.CLOCK(clock), .RESET(reset), .SPI_CS_N(cs_n),
    .SPI_SCLK(sclk), .SPI_DI(di), .SPI_DO(do_w), .SPI_DO_OE(do_oe),
    .FOUR_BYTE_MODE(four_b), .LOCK_MODE_SELECT(lms), .PROTECT_COMPLEMENT(comp_w),
    .TOP_BOTTOM_SELECT(top_w), .BLOCK_PROTECT_LEVEL(lvl), .WRITE_CHECK_ADDR(wr_addr),
    .WRITE_PERMIT(permit), .VOLATILE_CLEAR(vclear), .RESET_BUSY(busy));
  // a released output reads as the inverse of its last bit, so early sampling shows up
  assign do_line = do_oe ? do_w : ~do_w;
  blk_spi_host u_blk_spi_host (.CLOCK(clock), .SPI_DO(do_line), .SPI_CS_N(cs_n),
    .SPI_SCLK(sclk), .SPI_DI(di));

  // ----------------------------------------
  // monitors and helpers
  // ----------------------------------------
  always @(posedge clock) begin
    if (busy === 1'b1) busy_cnt++;
    if (vclear === 1'b1) clr_cnt++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [7:0] op, input logic [31:0] a, input int ab);
    u_blk_spi_host.frame({op, a << (32 - ab)}, 8 + ab, (op == OP_READ_LOCK) ? 8 : 0, rd);
  endtask : send

  task automatic blk(input logic [7:0] op, input int b);
    send(op, 32'(b) << 16, four_b ? 32 : 24);
  endtask : blk

  task automatic rdlk(input int b, input logic [7:0] exp);
    blk(OP_READ_LOCK, b);
    chk("lock_read", {24'h0, rd}, {24'h0, exp});
    chk("read_oe_off", {31'h0, do_oe}, 32'h0);
  endtask : rdlk

  // permit is registered one cycle after the address; sample two cycles later still
  task automatic perm(input int b, input logic exp);
    wr_addr <= 32'(b) << 16;
    repeat (3) @(posedge clock);
    chk("write_permit", {31'h0, permit}, {31'h0, exp});
  endtask : perm

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rdlk(5, 8'h01);
    perm(5, 1'b0);
  endtask : t_defaults

  task automatic t_single();
    blk(OP_UNLOCK_ONE, 5);
    rdlk(5, 8'h00);
    perm(5, 1'b1);
    perm(6, 1'b0);
    blk(OP_LOCK_ONE, 5);
    rdlk(5, 8'h01);
  endtask : t_single

  task automatic t_four();
    four_b <= 1'b1;
    @(posedge clock);
    send(OP_UNLOCK_ONE, 32'h0007_0000, 24); // short address is refused
    perm(7, 1'b0);
    blk(OP_UNLOCK_ONE, 7);
    rdlk(7, 8'h00);
    four_b <= 1'b0;
    @(posedge clock);
  endtask : t_four

  task automatic t_global();
    send(OP_UNLOCK_ALL, 0, 0);
    perm(0, 1'b1);
    perm(511, 1'b1);
    send(OP_LOCK_ALL, 0, 0);
    perm(0, 1'b0);
    perm(511, 1'b0);
  endtask : t_global

  // all lock bits are set here, so a permit proves they are bypassed
  task automatic t_level();
    lms <= 1'b0;
    perm(0, 1'b1);
    lvl <= 4'h1;
    top_w <= 1'b1;
    perm(0, 1'b0);
    perm(1, 1'b1);
    comp_w <= 1'b1;
    perm(0, 1'b1);
    perm(1, 1'b0);
    lms <= 1'b1;
    comp_w <= 1'b0;
    lvl <= 4'h0;
  endtask : t_level

  task automatic t_reset();
    int b0;
    send(OP_UNLOCK_ALL, 0, 0);
    send(OP_RESET_ENABLE, 0, 0);
    blk(OP_LOCK_ONE, 3);
    send(OP_RESET_DEVICE, 0, 0);
    perm(2, 1'b1);
    chk("clear_pulses", clr_cnt, 0);
    b0 = busy_cnt;
    chk("busy_before_reset", {31'h0, busy}, 32'h0);
    send(OP_RESET_ENABLE, 0, 0);
    send(OP_RESET_DEVICE, 0, 0);
    chk("clear_pulses", clr_cnt, 1);
    chk("reset_busy", {31'h0, busy}, 1);
    send(OP_UNLOCK_ALL, 0, 0); // must be ignored while busy
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clock);
    chk("busy_cycles", busy_cnt - b0, RESET_CYCLES);
    perm(2, 1'b0);
  endtask : t_reset

  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial begin
    reset = 1'b1;
    four_b = 1'b0;
    lms = 1'b1;
    comp_w = 1'b0;
    top_w = 1'b0;
    lvl = 4'h0;
    wr_addr = 32'h0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    // the bench sends no program, erase or status write, so only the select delay
    // is due here; the power-up write delay never comes into play
    repeat (SUPPLY_TO_SELECT_DELAY_US * 1000 / CLOCK_PERIOD_NS) @(posedge clock);
    t_defaults();
    t_single();
    t_four();
    t_global();
    t_level();
    t_reset();
    give_verdict();
  end

  // roughly 8.4k cycles expected; about seven times that means a hang
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
